//--- src/dblom_pkg.sv
/*
  Constants for the drop bus / line output mux: register map, field
  positions, reset values and drop bus bit lanes.
  Assumes an 8-bit parallel register port with 16-bit direct addresses.
*/
package dblom_pkg;

  // ----------------------------------------------------------------
  // Register port geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] LINE_IO_CONTROL_CH0_OFS = 16'h1F01;
  localparam logic [15:0] LINE_IO_CONTROL_CH4_OFS = 16'h5F01;
  localparam logic [15:0] MUX_CONTROL_OFS         = 16'h0100;
  localparam logic [15:0] MUX_STATUS_OFS          = 16'h0101;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned IOCTL_CLK_INVERT_BIT = 2;
  localparam int unsigned MUXCTL_TBUS_EN_BIT   = 0;
  localparam int unsigned MUXCTL_STS1_CH0_BIT  = 1;
  localparam int unsigned MUXCTL_STS1_CH4_BIT  = 2;
  localparam int unsigned STAT_FULL_BIT        = 0;
  localparam int unsigned STAT_EMPTY_BIT       = 1;
  localparam int unsigned STAT_TBUS_BIT        = 2;
  localparam int unsigned STAT_PIN_TWO_BIT     = 3;
  localparam int unsigned STAT_PIN_THREE_BIT   = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LINE_IO_CONTROL_RST = 8'h00;
  localparam logic [7:0] MUX_CONTROL_RST     = 8'h00;
  localparam logic [7:0] READ_UNMAPPED       = 8'h00;

  // ----------------------------------------------------------------
  // Drop bus lanes carried by the shared pins
  // ----------------------------------------------------------------
  localparam int unsigned DROP_BUS_W     = 8;
  localparam int unsigned DROP_BIT_TWO   = 2;
  localparam int unsigned DROP_BIT_THREE = 3;
  localparam int unsigned SYNC_STAGES    = 3;

endpackage : dblom_pkg

//--- src/dblom_edge_if.sv
/*
  Edge event carrier between the clock edge finder and the mux core.
  Assumes both ends run on mclk_i.
*/
`timescale 1ns/1ps

interface dblom_edge_if;
  logic rise;
  logic fall;
  logic level;

  modport src (output rise, output fall, output level);
  modport snk (input  rise, input  fall, input  level);
endinterface : dblom_edge_if

//--- src/dblom_clk_edge.sv
/*
  Samples a foreign clock with mclk_i and reports its filtered edges.
  Assumes the sampled clock is well below half the mclk_i rate.
*/
`timescale 1ns/1ps

module dblom_clk_edge
  import dblom_pkg::*;
(
  input  wire logic   mclk_i,
  input  wire logic   nrst_i,
  input  wire logic   raw_i,
  dblom_edge_if.src   edge_o
);

  logic [SYNC_STAGES-1:0] sync_r;
  logic                   filt_r;
  logic                   stable;

  // ----------------------------------------------------------------
  // Synchroniser; first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_r <= '0;
    end else begin
      sync_r <= {sync_r[SYNC_STAGES-2:0], raw_i};
    end
  end

  // Change counts once stages two and three agree
  assign stable = (sync_r[1] == sync_r[2]);

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      filt_r <= 1'b0;
    end else if (stable) begin
      filt_r <= sync_r[2];
    end
  end

  assign edge_o.rise  = stable &  sync_r[2] & ~filt_r;
  assign edge_o.fall  = stable & ~sync_r[2] &  filt_r;
  assign edge_o.level = filt_r;

endmodule : dblom_clk_edge

//--- src/dblom_top.sv
/*
  Output mux for the two shared pins of channel 0: drop bus bits 2/3
  or single-rail line transmit data of channels 0 and 4.
  Assumes a single-cycle write/read strobe register port on mclk_i and
  foreign clocks sampled on mclk_i.
*/
// Notes on behaviour
// R1: Each shared pin carries drop bus data when the channel 0 telecom bus is enabled, else line transmit data.
// R2: With the telecom bus enabled each pin shows its drop bus bit, changed on a rising drop bus clock edge.
// R3: With the telecom bus off the bit-two pin carries channel 0 line data and the bit-three pin channel 4 line data.
// R4: Line data is by default updated on the rising edge of that channel's line output clock.
// R5: In DS3/E3 mode a set bit 2 of the channel I/O control register moves the update to the falling edge.
// R6: In STS-1 mode the update stays on the rising edge whatever the invert bit says.
// R7: The board wires each line data pin to the positive-rail or data input of the matching line interface unit.
// R8: The mux select follows a stored telecom bus enable bit and changes only when software writes it.
`timescale 1ns/1ps

module dblom_top
  import dblom_pkg::*;
#(
  parameter int unsigned BUF_WIDTH = DROP_BUS_W,
  parameter int unsigned BUF_DEPTH = 2
) (
  input  wire logic                 mclk_i,
  input  wire logic                 nrst_i,
  input  wire logic [ADDR_W-1:0]    cpu_addr_i,
  input  wire logic [DATA_W-1:0]    cpu_wdata_i,
  input  wire logic                 cpu_wr_i,
  input  wire logic                 cpu_rd_i,
  output logic      [DATA_W-1:0]    cpu_rdata_o,
  input  wire logic [BUF_WIDTH-1:0] drop_data_i,
  input  wire logic                 drop_valid_i,
  output logic                      drop_ready_o,
  input  wire logic                 line_data_ch0_i,
  input  wire logic                 line_data_ch4_i,
  output logic                      line_take_ch0_o,
  output logic                      line_take_ch4_o,
  input  wire logic                 drop_bus_clock_i,
  input  wire logic                 line_tx_clock_ch0_i,
  input  wire logic                 line_tx_clock_ch4_i,
  output logic                      drop_bus_bit_two_o,
  output logic                      drop_bus_bit_three_o
);

  localparam int unsigned PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(BUF_DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(BUF_DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(BUF_DEPTH);

  logic [DATA_W-1:0]    ioctl_ch0_r;
  logic [DATA_W-1:0]    ioctl_ch4_r;
  logic [DATA_W-1:0]    muxctl_r;
  logic [BUF_WIDTH-1:0] buf_mem [BUF_DEPTH];
  logic [PTR_W-1:0]     wr_ptr_r;
  logic [PTR_W-1:0]     rd_ptr_r;
  logic [CNT_W-1:0]     cnt_r;
  logic                 pin_two_r;
  logic                 pin_three_r;
  logic                 tbus_en;
  logic                 buf_full;
  logic                 buf_empty;
  logic                 push;
  logic                 pop;
  logic                 fall_sel_ch0;
  logic                 fall_sel_ch4;
  logic                 upd_ch0;
  logic                 upd_ch4;
  logic [DATA_W-1:0]    status;

  dblom_edge_if drop_edge ();
  dblom_edge_if ch0_edge ();
  dblom_edge_if ch4_edge ();

  // ----------------------------------------------------------------
  // Foreign clock edge finders
  // ----------------------------------------------------------------
  dblom_clk_edge u_drop_edge (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .raw_i  (drop_bus_clock_i),
    .edge_o (drop_edge)
  );

  dblom_clk_edge u_ch0_edge (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .raw_i  (line_tx_clock_ch0_i),
    .edge_o (ch0_edge)
  );

  dblom_clk_edge u_ch4_edge (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .raw_i  (line_tx_clock_ch4_i),
    .edge_o (ch4_edge)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Select only moves on a software write, never on line activity
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      muxctl_r <= MUX_CONTROL_RST;
    end else if (cpu_wr_i && cpu_addr_i == MUX_CONTROL_OFS) begin
      muxctl_r <= cpu_wdata_i; // [R8]
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ioctl_ch0_r <= LINE_IO_CONTROL_RST;
      ioctl_ch4_r <= LINE_IO_CONTROL_RST;
    end else if (cpu_wr_i) begin
      if (cpu_addr_i == LINE_IO_CONTROL_CH0_OFS) begin
        ioctl_ch0_r <= cpu_wdata_i;
      end
      if (cpu_addr_i == LINE_IO_CONTROL_CH4_OFS) begin
        ioctl_ch4_r <= cpu_wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  assign status = {3'h0, pin_three_r, pin_two_r, tbus_en, buf_empty, buf_full};

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cpu_rdata_o <= READ_UNMAPPED;
    end else if (cpu_rd_i) begin
      case (cpu_addr_i)
        LINE_IO_CONTROL_CH0_OFS: cpu_rdata_o <= ioctl_ch0_r;
        LINE_IO_CONTROL_CH4_OFS: cpu_rdata_o <= ioctl_ch4_r;
        MUX_CONTROL_OFS:         cpu_rdata_o <= muxctl_r;
        MUX_STATUS_OFS:          cpu_rdata_o <= status;
        default:                 cpu_rdata_o <= READ_UNMAPPED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign tbus_en = muxctl_r[MUXCTL_TBUS_EN_BIT]; // [R1] [R8]

  // STS-1 ignores the invert bit; falling edge is DS3/E3 only
  assign fall_sel_ch0 = ioctl_ch0_r[IOCTL_CLK_INVERT_BIT] & ~muxctl_r[MUXCTL_STS1_CH0_BIT]; // [R5] [R6]
  assign fall_sel_ch4 = ioctl_ch4_r[IOCTL_CLK_INVERT_BIT] & ~muxctl_r[MUXCTL_STS1_CH4_BIT]; // [R5] [R6]

  assign upd_ch0 = fall_sel_ch0 ? ch0_edge.fall : ch0_edge.rise; // [R4] [R5] [R6]
  assign upd_ch4 = fall_sel_ch4 ? ch4_edge.fall : ch4_edge.rise; // [R4] [R5] [R6]

  assign line_take_ch0_o = ~tbus_en & upd_ch0;
  assign line_take_ch4_o = ~tbus_en & upd_ch4;

  // ----------------------------------------------------------------
  // Two-entry drop data buffer
  // ----------------------------------------------------------------
  // Drained only on drop clock edges, so a slow bus back-pressures the source
  assign buf_full     = (cnt_r == CNT_FULL);
  assign buf_empty    = (cnt_r == '0);
  assign drop_ready_o = ~buf_full;
  assign push         = drop_valid_i & ~buf_full;
  assign pop          = tbus_en & drop_edge.rise & ~buf_empty; // [R2]

  always_ff @(posedge mclk_i) begin
    if (push) begin
      buf_mem[wr_ptr_r] <= drop_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared pin registers
  // ----------------------------------------------------------------
  // Pin holds its last value across a mode switch until the new edge
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_two_r <= 1'b0;
    end else if (tbus_en) begin
      if (pop) begin
        pin_two_r <= buf_mem[rd_ptr_r][DROP_BIT_TWO]; // [R1] [R2]
      end
    end else if (upd_ch0) begin
      pin_two_r <= line_data_ch0_i; // [R1] [R3] [R4]
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_three_r <= 1'b0;
    end else if (tbus_en) begin
      if (pop) begin
        pin_three_r <= buf_mem[rd_ptr_r][DROP_BIT_THREE]; // [R1] [R2]
      end
    end else if (upd_ch4) begin
      pin_three_r <= line_data_ch4_i; // [R1] [R3] [R4]
    end
  end

  // Board ties these to the line unit positive-rail data input [R7]
  assign drop_bus_bit_two_o   = pin_two_r;
  assign drop_bus_bit_three_o = pin_three_r;

endmodule : dblom_top

//--- sim/dblom_asserts.sv
/*
  Checker on the dblom_top ports: pin source, edge choice, stall.
  Assumes it is bound onto dblom_top; control writes are shadowed here.
*/
`timescale 1ns/1ps
module dblom_asserts
  import dblom_pkg::*;
(
  input wire logic              mclk_i,
  input wire logic              nrst_i,
  input wire logic [ADDR_W-1:0] cpu_addr_i,
  input wire logic [DATA_W-1:0] cpu_wdata_i,
  input wire logic              cpu_wr_i,
  input wire logic              drop_ready_o,
  input wire logic              line_data_ch0_i,
  input wire logic              line_data_ch4_i,
  input wire logic              line_take_ch0_o,
  input wire logic              line_take_ch4_o,
  input wire logic              drop_bus_clock_i,
  input wire logic              line_tx_clock_ch0_i,
  input wire logic              line_tx_clock_ch4_i,
  input wire logic              drop_bus_bit_two_o,
  input wire logic              drop_bus_bit_three_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  logic [7:0] ctl_r;
  logic [7:0] io0_r;
  logic [7:0] io4_r;
  logic       tb;
  logic       lvl0;
  logic       lvl4;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_r <= MUX_CONTROL_RST;
      io0_r <= LINE_IO_CONTROL_RST;
      io4_r <= LINE_IO_CONTROL_RST;
    end else if (cpu_wr_i) begin
      if (cpu_addr_i == MUX_CONTROL_OFS) ctl_r <= cpu_wdata_i;
      if (cpu_addr_i == LINE_IO_CONTROL_CH0_OFS) io0_r <= cpu_wdata_i;
      if (cpu_addr_i == LINE_IO_CONTROL_CH4_OFS) io4_r <= cpu_wdata_i;
    end
  end
  // STS-1 ignores the invert bit, so only DS3/E3 may use the low level
  assign tb   = ctl_r[MUXCTL_TBUS_EN_BIT];
  assign lvl0 = !(io0_r[IOCTL_CLK_INVERT_BIT] && !ctl_r[MUXCTL_STS1_CH0_BIT]);
  assign lvl4 = !(io4_r[IOCTL_CLK_INVERT_BIT] && !ctl_r[MUXCTL_STS1_CH4_BIT]);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  edge_ch_zero_a: assert property (line_take_ch0_o |-> $past(line_tx_clock_ch0_i, 2) == lvl0)
    else $error("ch0 line bit taken on wrong clock edge");
  edge_ch_four_a: assert property (line_take_ch4_o |-> $past(line_tx_clock_ch4_i, 2) == lvl4)
    else $error("ch4 line bit taken on wrong clock edge");
  pin_two_line_a: assert property (line_take_ch0_o && !tb |=> drop_bus_bit_two_o == $past(line_data_ch0_i))
    else $error("bit-two pin lost ch0 line bit");
  pin_three_line_a: assert property (line_take_ch4_o && !tb |=> drop_bus_bit_three_o == $past(line_data_ch4_i))
    else $error("bit-three pin lost ch4 line bit");
  no_take_tbus_a: assert property (tb |-> !line_take_ch0_o && !line_take_ch4_o)
    else $error("line bit taken in telecom bus mode");
  // Mode must have stood a cycle: an update launched on the switching edge belongs to the old function
  drop_change_a: assert property (tb && $past(tb) && $changed(drop_bus_bit_three_o) |-> $past(drop_bus_clock_i, 3))
    else $error("drop pin moved without drop clock rise");
  line_change_a: assert property (!tb && !$past(tb) && $changed(drop_bus_bit_two_o) |-> $past(line_take_ch0_o))
    else $error("line pin moved without take");
  stall_hold_a: assert property (!drop_ready_o && !tb |=> !drop_ready_o)
    else $error("buffer drained while telecom bus off");
  cover property (line_take_ch0_o && !lvl0);
  cover property (tb && $changed(drop_bus_bit_two_o));
  cover property (!drop_ready_o && !tb);
endmodule // dblom_asserts

bind dblom_top dblom_asserts u_asserts (.*);

//--- sim/dblom_clk_model.sv
/*
  Far side clock source: line clocks ch0/ch4 and drop clock, 64 ns.
  Assumes run_i never changes at a toggle time.
*/
`timescale 1ns/1ps
module dblom_clk_model (
  input  wire logic run_i,
  output logic      line_clk0_o,
  output logic      line_clk4_o,
  output logic      drop_clk_o
);
  // Pins feed the positive-rail input of the same channel
  // Clocks stand still low between bursts
  initial begin
    line_clk0_o = 1'h0;
    line_clk4_o = 1'h0;
    drop_clk_o  = 1'h0;
    #3;
    forever begin
      #32;
      line_clk0_o = run_i ? !line_clk0_o : 1'h0;
      line_clk4_o = line_clk0_o;
      drop_clk_o  = line_clk0_o;
    end
  end
endmodule // dblom_clk_model

//--- sim/drop_bus_line_output_mux_tb.sv
/*
  Self-checking bench for dblom_top: registers, line mode, drop bus.
  Assumes dblom_clk_model supplies the foreign clocks.
*/
`timescale 1ns/1ps
module drop_bus_line_output_mux_tb;
  import dblom_pkg::*;
  logic        mclk_i, nrst_i, cpu_wr_i, cpu_rd_i, drop_valid_i, drop_ready_o, rd_seen, run, rnd;
  logic        line_data_ch0_i, line_data_ch4_i, drop_bus_clock_i, line_tx_clock_ch0_i, line_tx_clock_ch4_i;
  logic        drop_bus_bit_two_o, drop_bus_bit_three_o;
  logic [15:0] cpu_addr_i;
  logic [7:0]  cpu_wdata_i, cpu_rdata_o, drop_data_i, v, b1, b2, b3;
  logic [7:0]  exp_q[$];
  int          miscompares, n_checks;
  dblom_top u_dut (.mclk_i, .nrst_i, .cpu_addr_i, .cpu_wdata_i, .cpu_wr_i, .cpu_rd_i, .cpu_rdata_o,
    .drop_data_i, .drop_valid_i, .drop_ready_o, .line_data_ch0_i, .line_data_ch4_i, .line_take_ch0_o(),
    .line_take_ch4_o(), .drop_bus_clock_i, .line_tx_clock_ch0_i, .line_tx_clock_ch4_i,
    .drop_bus_bit_two_o, .drop_bus_bit_three_o);
  dblom_clk_model u_clk (.run_i(run), .line_clk0_o(line_tx_clock_ch0_i), .line_clk4_o(line_tx_clock_ch4_i),
    .drop_clk_o(drop_bus_clock_i));
  function automatic logic [7:0] st(input logic f, input logic e, input logic t, input logic a, input logic b);
    return (8'(f) << STAT_FULL_BIT) | (8'(e) << STAT_EMPTY_BIT) | (8'(t) << STAT_TBUS_BIT)
      | (8'(a) << STAT_PIN_TWO_BIT) | (8'(b) << STAT_PIN_THREE_BIT);
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
    n_checks++;
    if (seen !== expv) begin
      miscompares++;
      $display("wrong value at %0t: read %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    cpu_addr_i = a;
    cpu_wdata_i = d;
    cpu_wr_i = 1'h1;
    @(negedge mclk_i);
    cpu_wr_i = 1'h0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge mclk_i);
    cpu_addr_i = a;
    cpu_rd_i = 1'h1;
    exp_q.push_back(e);
    @(negedge mclk_i);
    cpu_rd_i = 1'h0;
  endtask
  // Runs all far-side clocks for n periods; random line bits if r
  task automatic burst(input int n, input logic r);
    @(negedge mclk_i);
    rnd = r;
    run = 1'h1;
    #(n * 64 + 2);
    run = 1'h0;
    rnd = 1'h0;
    repeat (20) @(negedge mclk_i);
  endtask
  task automatic push(input logic [7:0] d);
    @(negedge mclk_i);
    drop_data_i = d;
    drop_valid_i = 1'h1;
    @(posedge mclk_i);
  endtask
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    mclk_i = 1'h0;
    forever #4 mclk_i = !mclk_i;
  end
  always @(posedge mclk_i) begin
    if (rd_seen) chk(cpu_rdata_o, exp_q.pop_front());
    rd_seen <= cpu_rd_i;
  end
  always @(negedge mclk_i) begin
    if (rnd) begin
      line_data_ch0_i <= 1'($urandom);
      line_data_ch4_i <= 1'($urandom);
    end
  end
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
  initial begin
    {nrst_i, cpu_wr_i, cpu_rd_i, drop_valid_i, rd_seen, run, rnd, line_data_ch0_i, line_data_ch4_i} = 9'h000;
    {cpu_addr_i, cpu_wdata_i, drop_data_i} = 32'h0;
    miscompares = 0;
    n_checks = 0;
    void'($urandom(85224));
    repeat (4) @(negedge mclk_i);
    nrst_i = 1'h1;
    rd(MUX_CONTROL_OFS, MUX_CONTROL_RST);
    rd(LINE_IO_CONTROL_CH0_OFS, LINE_IO_CONTROL_RST);
    rd(LINE_IO_CONTROL_CH4_OFS, LINE_IO_CONTROL_RST);
    rd(MUX_STATUS_OFS, st(1'h0, 1'h1, 1'h0, 1'h0, 1'h0));
    wr(16'h0200, 8'hFF);
    rd(16'h0200, READ_UNMAPPED);
    // DS3/E3 and STS-1, each with and without the invert bit
    for (int m = 0; m < 4; m++) begin
      v = 8'($urandom);
      v[IOCTL_CLK_INVERT_BIT] = m[0];
      wr(LINE_IO_CONTROL_CH0_OFS, v);
      wr(LINE_IO_CONTROL_CH4_OFS, v);
      rd(LINE_IO_CONTROL_CH0_OFS, v);
      wr(MUX_CONTROL_OFS, {5'h00, m[1], m[1], 1'h0});
      burst(12, 1'h1);
      line_data_ch0_i = 1'($urandom);
      line_data_ch4_i = 1'($urandom);
      burst(3, 1'h0);
      rd(MUX_STATUS_OFS, st(1'h0, 1'h1, 1'h0, line_data_ch0_i, line_data_ch4_i));
    end
    // Fill while the bus is off: nothing may drain
    {b1, b2, b3} = 24'($urandom);
    push(b1);
    push(b2);
    push(b3);
    rd(MUX_STATUS_OFS, st(1'h1, 1'h0, 1'h0, line_data_ch0_i, line_data_ch4_i));
    wr(MUX_CONTROL_OFS, 8'h01);
    rd(MUX_STATUS_OFS, st(1'h1, 1'h0, 1'h1, line_data_ch0_i, line_data_ch4_i));
    burst(1, 1'h0);
    drop_valid_i = 1'h0;
    rd(MUX_STATUS_OFS, st(1'h1, 1'h0, 1'h1, b1[2], b1[3]));
    burst(1, 1'h0);
    rd(MUX_STATUS_OFS, st(1'h0, 1'h0, 1'h1, b2[2], b2[3]));
    burst(2, 1'h0);
    rd(MUX_STATUS_OFS, st(1'h0, 1'h1, 1'h1, b3[2], b3[3]));
    wr(MUX_CONTROL_OFS, 8'h00);
    rd(MUX_STATUS_OFS, st(1'h0, 1'h1, 1'h0, b3[2], b3[3]));
    repeat (4) @(negedge mclk_i);
    finish_test();
  end
endmodule // drop_bus_line_output_mux_tb
